// ### afc_map.svh
//==========================================================
// afc register map and constants
//==========================================================
// Purpose: offsets, fault codes and limits of the axis fault checker
// Assumes: word addressed register port, 32-bit data
// Notes: definitions only
// How it works
// - limit after proximity fall, before index: 0065
// - one-way search, limit before proximity: 0066
// - reverse search, both limits before proximity: 0066
// - value beyond clockwise travel limit: 0067
// - value beyond counter-clockwise travel limit: 0068
// - motion without established origin refused: 0069
// - motion without servo lock refused: 0070
// - preset not BCD or out of range: 0071
// - emergency stop or motion during it: 0072
// - encoder data missing or link error: 0073
// - clean encoder data but invalid: 0074
// - position counter overflow: 0077
// - revolution count or compensated sum overflow: 0078
// - encoder backup power or internal fault: 0079
// - init data outside +-32767: 0080
// - one code word per axis, consecutive
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH

`define AFC_A_CTRL 8'h00
`define AFC_A_STATE 8'h01
`define AFC_A_CW0 8'h02
`define AFC_A_CCW0 8'h03
`define AFC_A_CW1 8'h04
`define AFC_A_CCW1 8'h05
`define AFC_A_ISTAT 8'h06
`define AFC_A_IMASK 8'h07
`define AFC_A_CODE0 8'h0F
`define AFC_A_CODE1 8'h10

`define AFC_CTRL_RESET 0
`define AFC_CTRL_SLOCK 1

`define AFC_C_NONE 16'h0000
`define AFC_C_NO_INDEX 16'h0065
`define AFC_C_NO_PROX 16'h0066
`define AFC_C_CW_LIM 16'h0067
`define AFC_C_CCW_LIM 16'h0068
`define AFC_C_HOME 16'h0069
`define AFC_C_SERVO 16'h0070
`define AFC_C_PRESET 16'h0071
`define AFC_C_ESTOP 16'h0072
`define AFC_C_ABS_LINK 16'h0073
`define AFC_C_ABS_DATA 16'h0074
`define AFC_C_POS_OVF 16'h0077
`define AFC_C_REVS 16'h0078
`define AFC_C_ABS_PWR 16'h0079
`define AFC_C_ABS_INIT 16'h0080

`define AFC_POS_MAX 32'h7FFFFFFF
`define AFC_POS_MIN 32'h80000000
`define AFC_REV_MAX 32'sd99999
`define AFC_INIT_MAX 32'sd32767
`define AFC_PRESET_MAX 32'sd99999999
`define AFC_CW_RST 32'h7FFFFFFF
`define AFC_CCW_RST 32'h80000001

`endif

// ### afc_pkg.sv
//==========================================================
// afc types
//==========================================================
// Purpose: carrier types of the axis fault checker
// Assumes: two axes
// Notes: constants live in afc_map.svh
package afc_pkg;

  typedef struct packed {
    logic prox;
    logic cw_lim;
    logic ccw_lim;
    logic index;
  } afc_pin_s;

  typedef struct packed {
    logic move_req;
    logic search_start;
    logic search_rev;
    logic preset_req;
    logic preset_neg;
    logic abs_rx_done;
    logic abs_rx_err;
    logic abs_timeout;
    logic abs_bad;
    logic abs_alarm;
    logic abs_init;
    logic abs_set;
    logic cnt_up;
    logic cnt_dn;
    logic [31:0] target;
    logic [31:0] abs_data;
    logic [31:0] preset_bcd;
    logic [31:0] abs_revs;
    logic [31:0] abs_comp;
  } afc_req_s;

  typedef enum logic [1:0] {
    AFC_S_IDLE,
    AFC_S_SEEK,
    AFC_S_IN_PROX,
    AFC_S_PAST_PROX
  } afc_search_e;

endpackage

// ### afc_checker.sv
//==========================================================
// afc_checker
//==========================================================
// Purpose: per-axis fault detection and code words for two axes
// Assumes: switch pins asynchronous, request struct on clk_sys
// Notes: first fault of an axis wins until error reset
//
// The plain strobed port and the register offsets were left to the implementer.
`include "afc_map.svh"

module afc_checker
  import afc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] addr, // register word address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic irq, // level interrupt
  input wire afc_pin_s pin [2], // switch pins per axis
  input wire logic estop_pin, // emergency stop pin
  input wire afc_req_s req [2], // motion and encoder events
  output logic [1:0] move_ok, // motion accepted, pulse
  output logic [1:0] home_ok, // origin established
  output logic [1:0][15:0] fault_code, // latched code per axis
  output logic [1:0][31:0] position // current position
);

  //==========================================================
  // helpers
  //==========================================================
  function automatic logic bcd_ok(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (v[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic signed [31:0] bcd_bin(input logic [31:0] v);
    logic signed [31:0] acc;
    acc = 32'sd0;
    for (int i = 7; i >= 0; i--) begin
      acc = 32'(acc * 32'sd10) + 32'(signed'({28'h0, v[i*4 +: 4]}));
    end
    return acc;
  endfunction

  // code for a value checked against the travel window
  function automatic logic [15:0] lim_code(input logic signed [31:0] v,
                                            input logic signed [31:0] cw,
                                            input logic signed [31:0] ccw);
    if (v > cw) begin
      return `AFC_C_CW_LIM;
    end else if (v < ccw) begin
      return `AFC_C_CCW_LIM;
    end else begin
      return `AFC_C_NONE;
    end
  endfunction

  //==========================================================
  // pin synchronisers
  //==========================================================
  afc_pin_s pin_m [2];
  afc_pin_s pin_s [2];
  afc_pin_s pin_d [2];
  logic estop_m, estop_s, estop_d;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < 2; a++) begin
        pin_m[a] <= '0;
        pin_s[a] <= '0;
        pin_d[a] <= '0;
      end
      estop_m <= 1'b0;
      estop_s <= 1'b0;
      estop_d <= 1'b0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        pin_m[a] <= pin[a];
        pin_s[a] <= pin_m[a];
        pin_d[a] <= pin_s[a];
      end
      estop_m <= estop_pin;
      estop_s <= estop_m;
      estop_d <= estop_s;
    end
  end

  //==========================================================
  // control registers
  //==========================================================
  logic [1:0] servo_lock;
  logic [1:0][31:0] cw_lim;
  logic [1:0][31:0] ccw_lim;
  logic [1:0] imask;
  logic err_reset;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      servo_lock <= 2'h0;
      cw_lim <= {`AFC_CW_RST, `AFC_CW_RST};
      ccw_lim <= {`AFC_CCW_RST, `AFC_CCW_RST};
      imask <= 2'h0;
    end else if (wr) begin
      if (addr == `AFC_A_CTRL) begin
        servo_lock <= wdata[`AFC_CTRL_SLOCK +: 2];
      end else if (addr == `AFC_A_CW0) begin
        cw_lim[0] <= wdata;
      end else if (addr == `AFC_A_CCW0) begin
        ccw_lim[0] <= wdata;
      end else if (addr == `AFC_A_CW1) begin
        cw_lim[1] <= wdata;
      end else if (addr == `AFC_A_CCW1) begin
        ccw_lim[1] <= wdata;
      end else if (addr == `AFC_A_IMASK) begin
        imask <= wdata[1:0];
      end
    end
  end

  // error reset is the write pulse itself, not a stored bit
  assign err_reset = wr && (addr == `AFC_A_CTRL) && wdata[`AFC_CTRL_RESET];

  //==========================================================
  // origin search sequencer
  //==========================================================
  afc_search_e search_st [2];
  logic [1:0] search_rev;
  logic [1:0] cw_seen;
  logic [1:0] ccw_seen;
  logic [1:0][15:0] search_code;
  logic [1:0] search_done;

  always_comb begin
    for (int a = 0; a < 2; a++) begin
      search_code[a] = `AFC_C_NONE;
      search_done[a] = 1'b0;
      case (search_st[a])
        AFC_S_SEEK: begin
          if (!pin_s[a].prox) begin
            if (!search_rev[a] && (pin_s[a].cw_lim || pin_s[a].ccw_lim)) begin
              search_code[a] = `AFC_C_NO_PROX;
            end else if (search_rev[a] && (cw_seen[a] || pin_s[a].cw_lim)
                         && (ccw_seen[a] || pin_s[a].ccw_lim)) begin
              search_code[a] = `AFC_C_NO_PROX;
            end
          end
        end
        AFC_S_PAST_PROX: begin
          if (pin_s[a].index && !pin_d[a].index) begin
            search_done[a] = 1'b1;
          end else if (pin_s[a].cw_lim || pin_s[a].ccw_lim) begin
            search_code[a] = `AFC_C_NO_INDEX;
          end
        end
        default: begin
          search_code[a] = `AFC_C_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int a = 0; a < 2; a++) begin
        search_st[a] <= AFC_S_IDLE;
      end
      search_rev <= 2'h0;
      cw_seen <= 2'h0;
      ccw_seen <= 2'h0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        if (err_reset || search_code[a] != `AFC_C_NONE || search_done[a]) begin
          search_st[a] <= AFC_S_IDLE;
        end else if (req[a].search_start && search_st[a] == AFC_S_IDLE) begin
          search_st[a] <= AFC_S_SEEK;
          search_rev[a] <= req[a].search_rev;
          cw_seen[a] <= 1'b0;
          ccw_seen[a] <= 1'b0;
        end else begin
          case (search_st[a])
            AFC_S_SEEK: begin
              // a reverse search bounces off the first limit, so remember it
              cw_seen[a] <= cw_seen[a] | pin_s[a].cw_lim;
              ccw_seen[a] <= ccw_seen[a] | pin_s[a].ccw_lim;
              if (pin_s[a].prox) begin
                search_st[a] <= AFC_S_IN_PROX;
              end
            end
            AFC_S_IN_PROX: begin
              if (!pin_s[a].prox) begin
                search_st[a] <= AFC_S_PAST_PROX;
              end
            end
            default: begin
              search_st[a] <= search_st[a];
            end
          endcase
        end
      end
    end
  end

  //==========================================================
  // fault detection, highest priority first
  //==========================================================
  logic [1:0][15:0] next_fault;
  logic [1:0] next_move_ok;
  logic signed [32:0] comp_sum [2];
  logic signed [31:0] preset_val [2];

  always_comb begin
    for (int a = 0; a < 2; a++) begin
      next_fault[a] = `AFC_C_NONE;
      next_move_ok[a] = 1'b0;
      comp_sum[a] = 33'(signed'(req[a].abs_revs)) + 33'(signed'(req[a].abs_comp));
      preset_val[a] = req[a].preset_neg ? -bcd_bin(req[a].preset_bcd) : bcd_bin(req[a].preset_bcd);
      if (estop_s && !estop_d) begin
        next_fault[a] = `AFC_C_ESTOP;
      end else if (req[a].abs_timeout || (req[a].abs_rx_done && req[a].abs_rx_err)) begin
        next_fault[a] = `AFC_C_ABS_LINK;
      end else if (req[a].abs_alarm) begin
        next_fault[a] = `AFC_C_ABS_PWR;
      end else if (req[a].abs_rx_done && req[a].abs_bad) begin
        next_fault[a] = `AFC_C_ABS_DATA;
      end else if (req[a].abs_init && (signed'(req[a].abs_data) > `AFC_INIT_MAX
                   || signed'(req[a].abs_data) < -`AFC_INIT_MAX)) begin
        next_fault[a] = `AFC_C_ABS_INIT;
      end else if (req[a].abs_set && (signed'(req[a].abs_revs) > `AFC_REV_MAX
                   || signed'(req[a].abs_revs) < -`AFC_REV_MAX
                   || comp_sum[a][32] != comp_sum[a][31])) begin
        next_fault[a] = `AFC_C_REVS;
      end else if (req[a].abs_rx_done) begin
        next_fault[a] = lim_code(req[a].abs_data, cw_lim[a], ccw_lim[a]);
      end else if (search_code[a] != `AFC_C_NONE) begin
        next_fault[a] = search_code[a];
      end else if ((req[a].cnt_up && position[a] == `AFC_POS_MAX)
                   || (req[a].cnt_dn && position[a] == `AFC_POS_MIN)) begin
        next_fault[a] = `AFC_C_POS_OVF;
      end else if (req[a].preset_req) begin
        if (!bcd_ok(req[a].preset_bcd) || bcd_bin(req[a].preset_bcd) > `AFC_PRESET_MAX) begin
          next_fault[a] = `AFC_C_PRESET;
        end else begin
          next_fault[a] = lim_code(preset_val[a], cw_lim[a], ccw_lim[a]);
        end
      end else if (req[a].move_req) begin
        if (estop_s) begin
          next_fault[a] = `AFC_C_ESTOP;
        end else if (!home_ok[a]) begin
          next_fault[a] = `AFC_C_HOME;
        end else if (!servo_lock[a]) begin
          next_fault[a] = `AFC_C_SERVO;
        end else begin
          next_fault[a] = lim_code(req[a].target, cw_lim[a], ccw_lim[a]);
          next_move_ok[a] = (next_fault[a] == `AFC_C_NONE) && (fault_code[a] == `AFC_C_NONE);
        end
      end
    end
  end

  //==========================================================
  // code words, position and origin state
  //==========================================================
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_code <= '0;
      move_ok <= 2'h0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        // a fault in the reset cycle survives the reset
        if (next_fault[a] != `AFC_C_NONE && (fault_code[a] == `AFC_C_NONE || err_reset)) begin
          fault_code[a] <= next_fault[a];
        end else if (err_reset) begin
          fault_code[a] <= `AFC_C_NONE;
        end
      end
      move_ok <= next_move_ok;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      position <= '0;
      home_ok <= 2'h0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        if (search_done[a]) begin
          position[a] <= '0;
          home_ok[a] <= 1'b1;
        end else if (req[a].abs_set && next_fault[a] == `AFC_C_NONE) begin
          position[a] <= comp_sum[a][31:0];
          home_ok[a] <= 1'b1;
        end else if (req[a].preset_req && next_fault[a] == `AFC_C_NONE) begin
          position[a] <= preset_val[a];
        end else if (req[a].cnt_up && !req[a].cnt_dn && position[a] != `AFC_POS_MAX) begin
          position[a] <= position[a] + 32'h1;
        end else if (req[a].cnt_dn && !req[a].cnt_up && position[a] != `AFC_POS_MIN) begin
          position[a] <= position[a] - 32'h1;
        end
        // a new search forgets the old origin
        if (req[a].search_start && search_st[a] == AFC_S_IDLE && !search_done[a]) begin
          home_ok[a] <= 1'b0;
        end
      end
    end
  end

  //==========================================================
  // interrupts
  //==========================================================
  logic [1:0] istat;
  logic [1:0] ipost;

  always_comb begin
    for (int a = 0; a < 2; a++) begin
      ipost[a] = (next_fault[a] != `AFC_C_NONE) && (fault_code[a] == `AFC_C_NONE || err_reset);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      istat <= 2'h0;
      irq <= 1'b0;
    end else begin
      // set wins over a write-one clear in the same cycle
      if (wr && addr == `AFC_A_ISTAT) begin
        istat <= (istat & ~wdata[1:0]) | ipost;
      end else begin
        istat <= istat | ipost;
      end
      irq <= |(istat & imask);
    end
  end

  //==========================================================
  // read port
  //==========================================================
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (rd) begin
      if (addr == `AFC_A_CTRL) begin
        rdata <= {29'h0, servo_lock, 1'b0};
      end else if (addr == `AFC_A_STATE) begin
        rdata <= {27'h0, estop_s, search_st[1] != AFC_S_IDLE, search_st[0] != AFC_S_IDLE, home_ok};
      end else if (addr == `AFC_A_CW0) begin
        rdata <= cw_lim[0];
      end else if (addr == `AFC_A_CCW0) begin
        rdata <= ccw_lim[0];
      end else if (addr == `AFC_A_CW1) begin
        rdata <= cw_lim[1];
      end else if (addr == `AFC_A_CCW1) begin
        rdata <= ccw_lim[1];
      end else if (addr == `AFC_A_ISTAT) begin
        rdata <= {30'h0, istat};
      end else if (addr == `AFC_A_IMASK) begin
        rdata <= {30'h0, imask};
      end else if (addr == `AFC_A_CODE0) begin
        rdata <= {16'h0, fault_code[0]};
      end else if (addr == `AFC_A_CODE1) begin
        rdata <= {16'h0, fault_code[1]};
      end else begin
        rdata <= '0;
      end
    end else begin
      rdata <= '0;
    end
  end

endmodule

// ### afc_checker_asserts.sv
// Purpose: port assertions for the axis fault checker
// Assumes: one clock, axis 0 watched in detail
// Notes: bound to every afc_checker instance
//=====
// checker
module afc_checker_asserts
  import afc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic [7:0] addr, // word address
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic estop_pin, // emergency stop
  input wire afc_req_s req [2], // events
  input wire logic [1:0] move_ok, // motion accepted
  input wire logic [1:0] home_ok, // origin set
  input wire logic [1:0][15:0] fault_code, // codes
  input wire logic [1:0][31:0] position // positions
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // two idle cycles after a write so a delayed error reset is not flagged
  chk_code_hold: assert property ((fault_code[0] != 16'h0000 && !wr && !$past(wr)) |=> $stable(fault_code[0]))
    else $error("code word changed without reset");
  chk_move_cause: assert property (move_ok[0] |-> $past(req[0].move_req) && $past(home_ok[0]))
    else $error("move accepted without request or origin");
  chk_move_clean: assert property (move_ok[0] |-> $past(fault_code[0]) == 16'h0000)
    else $error("move accepted with pending fault");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h00000000)
    else $error("read data outside its cycle");
  chk_code0_read: assert property ($past(rd) && $past(addr) == 8'h0F |-> rdata == {16'h0000, $past(fault_code[0])})
    else $error("first axis word wrong");
  chk_code1_read: assert property ($past(rd) && $past(addr) == 8'h10 |-> rdata == {16'h0000, $past(fault_code[1])})
    else $error("second axis word wrong");
  chk_estop_post: assert property ($rose(estop_pin) |-> ##[1:6] (fault_code[0] != 16'h0000 && fault_code[1] != 16'h0000))
    else $error("stop not posted on both axes");
  chk_count_sat: assert property (
    req[0].cnt_up && !req[0].cnt_dn && !req[0].abs_set && position[0] == 32'h7FFFFFFF
    |=> fault_code[0] != 16'h0000 && position[0] == 32'h7FFFFFFF)
    else $error("counter overflow missed");
  chk_code_legal: assert property (
    fault_code[0] inside {16'h0000, 16'h0065, 16'h0066, 16'h0067, 16'h0068, 16'h0069,
    16'h0070, 16'h0071, 16'h0072, 16'h0073, 16'h0074, 16'h0077, 16'h0078, 16'h0079, 16'h0080})
    else $error("unknown code value");
endmodule
bind afc_checker afc_checker_asserts u_chk (.clk_sys, .rstn, .addr, .wr, .rd, .rdata, .estop_pin, .req, .move_ok,
  .home_ok, .fault_code, .position);

// ### afc_field.sv
// Purpose: switch and stop pins of both axes
// Assumes: pins are levels, change after a clock edge
// Notes: the design syncs them, so callers wait a few cycles
//=====
// field model
module afc_field
  import afc_pkg::*;
(
  input wire logic clk_sys, // clock
  output afc_pin_s pin [2], // switches per axis
  output logic estop_pin // emergency stop
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin[0] = '0;
    pin[1] = '0;
    estop_pin = 1'b0;
  end
  task automatic sw(input int ax, input afc_pin_s v);
    @(posedge clk_sys);
    pin[ax] <= v;
  endtask
  task automatic stop(input logic v);
    @(posedge clk_sys);
    estop_pin <= v;
  endtask
endmodule

// ### afc_checker_tb_top.sv
// Purpose: register and event tests of the axis fault checker
// Assumes: codes read back at words 0F and 10
// Notes: every fault is cleared by an error reset before the next
//=====
// bench
module afc_checker_tb_top
  import afc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] F_MOVE = 14'h2000, F_START = 14'h1000, F_REV = 14'h0800, F_PRE = 14'h0400,
    F_NEG = 14'h0200, F_RXD = 14'h0100, F_RXE = 14'h0080, F_TMO = 14'h0040, F_BAD = 14'h0020,
    F_ALM = 14'h0010, F_INIT = 14'h0008, F_SET = 14'h0004, F_UP = 14'h0002, F_DN = 14'h0001;
  logic clk_sys, rstn, wr, rd, irq, estop_pin;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  afc_pin_s pin [2];
  afc_req_s req [2];
  logic [1:0] move_ok, home_ok, seen_ok, lock;
  logic [1:0][15:0] fault_code;
  logic [1:0][31:0] position;
  int failures = 0;
  int checked = 0;
  afc_checker dut (.clk_sys, .rstn, .addr, .wdata, .wr, .rd, .rdata, .irq, .pin, .estop_pin, .req, .move_ok,
    .home_ok, .fault_code, .position);
  afc_field field (.clk_sys, .pin, .estop_pin);
  always #5 clk_sys = ~clk_sys;
  // move_ok is a one-cycle pulse, so keep a sticky copy
  always @(posedge clk_sys) seen_ok <= seen_ok | move_ok;
  //=====
  // tasks
  task automatic end_sim;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk(rdata, e);
  endtask
  task automatic clr;
    bw(8'h00, {29'h0, lock, 1'b1});
    w(2);
  endtask
  task automatic ev(input int ax, input logic [13:0] f, input logic [31:0] v, c);
    @(negedge clk_sys);
    seen_ok = 2'b00;
    @(posedge clk_sys);
    req[ax] <= {f, v, v, v, v, c};
    @(posedge clk_sys);
    req[ax] <= '0;
    w(3);
  endtask
  task automatic fc(input int ax, input logic [15:0] code);
    chk(fault_code[ax], {16'h0000, code});
    rc(8'h0F + 8'(ax), {16'h0000, code});
    clr();
    rc(8'h0F + 8'(ax), 32'h0);
  endtask
  task automatic go(input int ax, input logic [13:0] f, input logic [31:0] v, c, input logic [15:0] code);
    ev(ax, f, v, c);
    chk(seen_ok[ax], f == F_MOVE && code == 16'h0000);
    fc(ax, code);
  endtask
  task automatic ps(input int ax, input logic [3:0] v);
    field.sw(ax, v);
    w(5);
  endtask
  //=====
  // sequence
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    lock = 2'b00;
    seen_ok = 2'b00;
    req[0] = '0;
    req[1] = '0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    w(3);
    rc(8'h0F, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'h02, 32'h7FFFFFFF);
    rc(8'h03, 32'h80000001);
    bw(8'h20, 32'hFFFFFFFF);
    rc(8'h20, 32'h0);
    bw(8'h07, 32'h1);
    ev(0, F_MOVE, 0, 0);
    chk(irq, 1'b1);
    bw(8'h06, 32'h1);
    w(2);
    chk(irq, 1'b0);
    fc(0, 16'h0069);
    go(0, F_INIT, 32'h00007FFF, 0, 16'h0000);
    go(0, F_INIT, 32'h00008000, 0, 16'h0080);
    go(0, F_INIT, 32'hFFFF8001, 0, 16'h0000);
    go(0, F_INIT, 32'hFFFF8000, 0, 16'h0080);
    go(0, F_TMO, 0, 0, 16'h0073);
    go(0, F_RXD | F_RXE, 0, 0, 16'h0073);
    go(0, F_RXD | F_BAD, 0, 0, 16'h0074);
    go(0, F_ALM, 0, 0, 16'h0079);
    go(0, F_SET, 32'h000186A0, 0, 16'h0078);
    go(0, F_SET, 32'hFFFE7960, 0, 16'h0078);
    go(0, F_SET, 32'h00000005, 32'h7FFFFFFF, 16'h0078);
    go(0, F_SET, 32'h0001869F, 0, 16'h0000);
    chk(position[0], 32'h0001869F);
    go(0, F_SET, 0, 32'h7FFFFFFE, 16'h0000);
    chk(home_ok[0], 1'b1);
    go(0, F_UP, 0, 0, 16'h0000);
    go(0, F_UP, 0, 0, 16'h0077);
    chk(position[0], 32'h7FFFFFFF);
    go(0, F_MOVE, 0, 0, 16'h0070);
    lock = 2'b01;
    bw(8'h00, 32'h2);
    bw(8'h02, 32'h000003E8);
    bw(8'h03, 32'hFFFFFC18);
    go(0, F_MOVE, 32'h000003E8, 0, 16'h0000);
    go(0, F_MOVE, 32'h000003E9, 0, 16'h0067);
    go(0, F_MOVE, 32'hFFFFFC18, 0, 16'h0000);
    go(0, F_MOVE, 32'hFFFFFC17, 0, 16'h0068);
    go(0, F_RXD, 32'h000003E9, 0, 16'h0067);
    go(0, F_RXD, 32'hFFFFFC17, 0, 16'h0068);
    go(0, F_PRE, 32'h00000500, 0, 16'h0000);
    go(0, F_PRE, 32'h0000001A, 0, 16'h0071);
    go(0, F_PRE, 32'h00001001, 0, 16'h0067);
    go(0, F_PRE | F_NEG, 32'h00001000, 0, 16'h0000);
    go(0, F_PRE | F_NEG, 32'h00001001, 0, 16'h0068);
    field.stop(1'b1);
    w(6);
    rc(8'h0F, 32'h0072);
    rc(8'h10, 32'h0072);
    clr();
    go(0, F_MOVE, 0, 0, 16'h0072);
    field.stop(1'b0);
    clr();
    go(0, F_MOVE, 0, 0, 16'h0000);
    ev(1, F_START, 0, 0);
    ps(1, 4'b0100);
    ps(1, 4'b0000);
    fc(1, 16'h0066);
    ev(1, F_START | F_REV, 0, 0);
    ps(1, 4'b0100);
    chk(fault_code[1], 32'h0);
    ps(1, 4'b0010);
    ps(1, 4'b0000);
    fc(1, 16'h0066);
    ev(1, F_START, 0, 0);
    ps(1, 4'b1000);
    ps(1, 4'b0000);
    ps(1, 4'b0010);
    ps(1, 4'b0000);
    fc(1, 16'h0065);
    ev(1, F_UP, 0, 0);
    ev(1, F_START, 0, 0);
    ps(1, 4'b1000);
    ps(1, 4'b0000);
    ps(1, 4'b0001);
    ps(1, 4'b0000);
    chk(home_ok[1], 1'b1);
    chk(position[1], 32'h0);
    fc(1, 16'h0000);
    go(1, F_DN, 0, 0, 16'h0000);
    chk(position[1], 32'hFFFFFFFF);
    end_sim();
  end
  // hang guard
  initial begin
    w(20000);
    failures++;
    end_sim();
  end
endmodule
